// ### spbcr_host.sv
// ---------------------------------------------------------------
// host configuration software: avalon-mm master
// ---------------------------------------------------------------
module spbcr_host
    import spbcr_pkg::*;
(
    // clock
    input wire logic core_clk,
    // avalon-mm master side
    output logic [9:0] avs_address,
    output logic avs_read,
    output logic avs_write,
    output logic [31:0] avs_writedata,
    output logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // raised when an access never completes
    output logic stuck
);
    timeunit 1ns;
    timeprecision 1ns;

    // idle bus at time zero
    initial
    begin
        avs_address = '0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = '0;
        avs_byteenable = '0;
        stuck = 1'b0;
    end

    // one access: held until waitrequest is sampled low, bounded wait
    // so a dead slave cannot hang the run
    task automatic xfer(input logic wr, input logic [9:0] a,
        input logic [31:0] d, input logic [3:0] be,
        output logic [31:0] q);
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= !wr;
        for (int n = 0; n < 50; n++)
        begin
            @(posedge core_clk);
            if (avs_waitrequest === 1'b0)
                break;
        end
        // no completion seen: flag it
        if (avs_waitrequest !== 1'b0)
            stuck <= 1'b1;
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
endmodule

// ### spbcr_pkg.sv
package spbcr_pkg;
    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_IRQ_PIN = 8'h3D;
    localparam logic [7:0] IDX_BRIDGE_CTL = 8'h3E;
    localparam logic [7:0] IDX_CAP_HDR = 8'h40;
    localparam logic [7:0] IDX_UNLOCK = 8'h50;
    localparam logic [7:0] IDX_STATUS = 8'h51;
    // ------------------------------------------------------------
    // bridge control field positions and write mask
    // ------------------------------------------------------------
    localparam int BC_POISON = 0;
    localparam int BC_ERR_FWD = 1;
    localparam int BC_ISA = 2;
    localparam int BC_VGA = 3;
    localparam int BC_VGA_WIDE = 4;
    localparam int BC_SBR = 6;
    localparam logic [15:0] BC_WMASK = 16'h005F;
    localparam logic [15:0] BC_RST = 16'h0000;
    localparam logic [7:0] IRQ_PIN_RST = 8'h00;
    // ------------------------------------------------------------
    // capability header values
    // ------------------------------------------------------------
    localparam logic [7:0] CAP_ID = 8'h10;
    localparam logic [7:0] NXT_PTR_RST = 8'hC0;
    localparam logic [3:0] VER_RST_1P1 = 4'h1;
    localparam logic [3:0] VER_RST_OTHER = 4'h2;
    localparam logic [3:0] TYPE_UP = 4'h5;
    localparam logic [3:0] TYPE_DN = 4'h6;
    localparam logic TCS_RST = 1'b1;
    localparam logic TCS_RST_1P1 = 1'b0;
    // ------------------------------------------------------------
    // I/O routing constants
    // ------------------------------------------------------------
    localparam logic [31:0] ISA_TOP = 32'h0001_0000;
    localparam logic [9:0] VGA_A_LO = 10'h3B0;
    localparam logic [9:0] VGA_A_HI = 10'h3BB;
    localparam logic [9:0] VGA_B_LO = 10'h3C0;
    localparam logic [9:0] VGA_B_HI = 10'h3DF;
    // ------------------------------------------------------------
    // bus handshake states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_ACK = 2'b10
    } spbcr_bus_e;
endpackage

// ### spbcr_regs.sv
// Chosen here: the Avalon-MM interface to the registers.
module spbcr_regs
    import spbcr_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // avalon-mm slave
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // straps
    input wire logic strap_upstream,
    input wire logic strap_mode_1p1,
    // error and poison events from the secondary side
    input wire logic sec_poison_seen,
    input wire logic sec_err_msg,
    input wire logic cmd_err_report_en,
    input wire logic devctl_err_report_en,
    output logic poison_report,
    output logic err_forward,
    // i/o routing request
    input wire logic io_valid,
    input wire logic [31:0] io_addr,
    input wire logic [31:0] io_base,
    input wire logic [31:0] io_limit,
    output logic io_route_down,
    output logic io_route_up,
    // legacy interrupt and bus reset
    input wire logic intx_request,
    output logic [3:0] intx_assert,
    output logic upstream_sbr,
    output logic downstream_sbr
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // byte-lane merge of a write into a word
    function automatic logic [31:0] lane_merge(
        input logic [31:0] old_w,
        input logic [31:0] wd,
        input logic [3:0] be
    );
        logic [31:0] r;
        r = old_w;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
            begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // vga compatible i/o address; narrow mode aliases every 1 KB
    function automatic logic vga_hit(
        input logic [31:0] a,
        input logic wide
    );
        logic in_a;
        logic in_b;
        in_a = (a[9:0] >= VGA_A_LO) && (a[9:0] <= VGA_A_HI);
        in_b = (a[9:0] >= VGA_B_LO) && (a[9:0] <= VGA_B_HI);
        return (in_a || in_b) && (!wide || (a[31:10] == 22'h0));
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    spbcr_bus_e st_q; // handshake state
    logic wait_q; // waitrequest flop
    logic [31:0] rdata_q; // read data held for the ack edge
    logic [7:0] irq_pin_q; // legacy pin select
    logic [15:0] bctl_q; // bridge control
    logic [7:0] nxt_ptr_q; // next capability pointer
    logic [3:0] ver_q; // capability version
    logic slot_q; // slot implemented
    logic tcs_q; // traffic class routing support
    logic unlock_q; // opens lockable fields
    logic init_q; // straps captured
    logic port_up_q; // captured upstream strap
    logic mode_1p1_q; // captured 1.1 mode strap
    logic poison_q;
    logic errfwd_q;
    logic down_q;
    logic up_q;
    logic [3:0] intx_q;
    logic usbr_q;
    logic dsbr_q;

    // ------------------------------------------------------------
    // address decode and write data
    // ------------------------------------------------------------
    wire logic [7:0] idx = avs_address[9:2];
    wire logic sel_pin = (idx == IDX_IRQ_PIN);
    wire logic sel_bctl = (idx == IDX_BRIDGE_CTL);
    wire logic sel_cap = (idx == IDX_CAP_HDR);
    wire logic sel_unl = (idx == IDX_UNLOCK);
    wire logic sel_sts = (idx == IDX_STATUS);
    // writes land only on the edge that sees waitrequest low
    wire logic wr_fire = (st_q == ST_ACK) && avs_write;
    // read data is only captured once the straps are known
    wire logic rd_start = (st_q == ST_IDLE) && avs_read && init_q;
    wire logic [3:0] type_w = port_up_q ? TYPE_UP : TYPE_DN;

    // register images as software sees them
    wire logic [31:0] pin_word = {24'h0, irq_pin_q};
    wire logic [31:0] bctl_word = {16'h0, bctl_q};
    // message number always zero, top bit reserved
    wire logic [31:0] cap_word = {1'b0, tcs_q, 5'h00, slot_q,
        type_w, ver_q, nxt_ptr_q, CAP_ID};
    wire logic [31:0] unl_word = {31'h0, unlock_q};
    wire logic [31:0] sts_word = {28'h0, dsbr_q, usbr_q,
        mode_1p1_q, port_up_q};

    // read mux; unmapped words read zero
    wire logic [31:0] rd_word =
        sel_pin ? pin_word :
        sel_bctl ? bctl_word :
        sel_cap ? cap_word :
        sel_unl ? unl_word :
        sel_sts ? sts_word : 32'h0;

    wire logic [31:0] pin_m = lane_merge(pin_word, avs_writedata,
        avs_byteenable);
    wire logic [31:0] bctl_m = lane_merge(bctl_word, avs_writedata,
        avs_byteenable);
    wire logic [31:0] cap_m = lane_merge(cap_word, avs_writedata,
        avs_byteenable);
    wire logic [31:0] unl_m = lane_merge(unl_word, avs_writedata,
        avs_byteenable);
    wire logic [15:0] bctl_d = bctl_m[15:0] & BC_WMASK;
    // lockable fields take writes only while unlocked
    wire logic cap_wr = wr_fire && sel_cap && unlock_q;

    // ------------------------------------------------------------
    // bus handshake: one wait cycle, then one ack cycle
    // ------------------------------------------------------------
    // waitrequest idles high so no request completes by accident
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_q <= ST_IDLE;
            wait_q <= 1'b1;
        end
        else
        begin
            unique case (st_q)
                ST_IDLE:
                begin
                    // requests wait until the straps are captured, so the
                    // port type and version never read their reset values
                    if ((avs_read || avs_write) && init_q)
                    begin
                        st_q <= ST_ACK;
                        wait_q <= 1'b0;
                    end
                end
                ST_ACK:
                begin
                    st_q <= ST_IDLE;
                    wait_q <= 1'b1;
                end
            endcase
        end
    end

    // read data sampled one cycle early so it stands at the ack edge
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata_q <= 32'h0;
        end
        else if (rd_start)
        begin
            rdata_q <= rd_word;
        end
    end

    // ------------------------------------------------------------
    // plain read/write registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_pin_q <= IRQ_PIN_RST;
            bctl_q <= BC_RST;
            unlock_q <= 1'b0;
        end
        else if (wr_fire)
        begin
            // codes above four are stored but drive no line
            if (sel_pin)
            begin
                irq_pin_q <= pin_m[7:0];
            end
            if (sel_bctl)
            begin
                bctl_q <= bctl_d;
            end
            if (sel_unl)
            begin
                unlock_q <= unl_m[0];
            end
        end
    end

    // ------------------------------------------------------------
    // strap capture and lockable capability fields
    // ------------------------------------------------------------
    // straps are caught on the first edge after reset release,
    // since an async reset may only load constants
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            init_q <= 1'b0;
            port_up_q <= 1'b0;
            mode_1p1_q <= 1'b0;
            nxt_ptr_q <= NXT_PTR_RST;
            ver_q <= VER_RST_1P1;
            slot_q <= 1'b0;
            tcs_q <= TCS_RST;
        end
        else if (!init_q)
        begin
            init_q <= 1'b1;
            port_up_q <= strap_upstream;
            mode_1p1_q <= strap_mode_1p1;
            ver_q <= strap_mode_1p1 ? VER_RST_1P1 : VER_RST_OTHER;
            tcs_q <= strap_mode_1p1 ? TCS_RST_1P1 : TCS_RST;
        end
        else if (cap_wr)
        begin
            nxt_ptr_q <= cap_m[15:8];
            ver_q <= cap_m[19:16];
            slot_q <= cap_m[24];
            tcs_q <= cap_m[30];
        end
    end

    // ------------------------------------------------------------
    // routing and event logic
    // ------------------------------------------------------------
    wire logic in_rng = (io_addr >= io_base) && (io_addr <= io_limit);
    // isa: top 768 bytes of each 1 KB block below 64 KB go up
    wire logic isa_up = bctl_q[BC_ISA] && in_rng &&
        (io_addr < ISA_TOP) && (io_addr[9:8] != 2'b00);
    // width bit is only consulted through a set vga enable
    wire logic vga_fwd = bctl_q[BC_VGA] &&
        vga_hit(io_addr, bctl_q[BC_VGA_WIDE]);
    wire logic go_down = io_valid && (vga_fwd || (in_rng && !isa_up));
    wire logic go_up = io_valid && !go_down;
    wire logic err_en = cmd_err_report_en || devctl_err_report_en;
    wire logic [3:0] intx_d =
        !intx_request ? 4'h0 :
        (irq_pin_q == 8'h01) ? 4'h1 :
        (irq_pin_q == 8'h02) ? 4'h2 :
        (irq_pin_q == 8'h03) ? 4'h4 :
        (irq_pin_q == 8'h04) ? 4'h8 : 4'h0;

    // registered outputs, one cycle behind their cause
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            poison_q <= 1'b0;
            errfwd_q <= 1'b0;
            down_q <= 1'b0;
            up_q <= 1'b0;
            intx_q <= 4'h0;
            usbr_q <= 1'b0;
            dsbr_q <= 1'b0;
        end
        else
        begin
            poison_q <= sec_poison_seen && bctl_q[BC_POISON];
            errfwd_q <= sec_err_msg && bctl_q[BC_ERR_FWD] && err_en;
            down_q <= go_down;
            up_q <= go_up;
            intx_q <= intx_d;
            usbr_q <= bctl_q[BC_SBR] && port_up_q;
            dsbr_q <= bctl_q[BC_SBR] && !port_up_q;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign avs_readdata = rdata_q;
    assign avs_waitrequest = wait_q;
    assign poison_report = poison_q;
    assign err_forward = errfwd_q;
    assign io_route_down = down_q;
    assign io_route_up = up_q;
    assign intx_assert = intx_q;
    assign upstream_sbr = usbr_q;
    assign downstream_sbr = dsbr_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    wire logic rd_ack = (st_q == ST_ACK) && avs_read;

    AST_CAP_ID: assert property (@(posedge core_clk) disable iff (!rst_n)
        rd_ack && sel_cap |-> avs_readdata[7:0] == CAP_ID)
        else $error("capability id wrong");

    AST_PORT_TYPE: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        rd_ack && sel_cap && init_q |->
        avs_readdata[23:20] == (port_up_q ? 4'h5 : 4'h6))
        else $error("port type wrong");

    AST_MSG_NUM: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        rd_ack && sel_cap |-> avs_readdata[29:25] == 5'h00 &&
        !avs_readdata[31])
        else $error("message number not zero");

    AST_BCTL_RSV: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        wr_fire && sel_bctl |=> bctl_q[15:7] == 9'h000 && !bctl_q[5])
        else $error("reserved control bit set");

    AST_LOCKED: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        init_q && !unlock_q && wr_fire && sel_cap |=>
        $stable(nxt_ptr_q) && $stable(ver_q) && $stable(tcs_q))
        else $error("locked field changed");

    // the strap-dependent defaults must load on the capture edge
    AST_STRAP_RST: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        !init_q |=> ver_q == ($past(strap_mode_1p1) ? VER_RST_1P1 :
        VER_RST_OTHER) && tcs_q == ($past(strap_mode_1p1) ? TCS_RST_1P1 :
        TCS_RST))
        else $error("strap defaults not loaded");

    AST_POISON: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        sec_poison_seen |=> poison_report == $past(bctl_q[BC_POISON]))
        else $error("poison report wrong");

    AST_ERR_GATE: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        !cmd_err_report_en && !devctl_err_report_en |=> !err_forward)
        else $error("error forwarded while reporting off");

    AST_INTA: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        intx_request && irq_pin_q == 8'h01 |=> intx_assert == 4'h1)
        else $error("INTA not signalled");

    AST_ISA_UP: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        io_valid && bctl_q[BC_ISA] && !bctl_q[BC_VGA] && in_rng &&
        io_addr < ISA_TOP && io_addr[9:8] != 2'b00 |=>
        io_route_up && !io_route_down)
        else $error("isa address not sent upstream");

    AST_SBR: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        bctl_q[BC_SBR] && init_q |=> upstream_sbr != downstream_sbr)
        else $error("bus reset not driven");

    AST_HANDSHAKE: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        !avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low twice");
endmodule

// ### spbcr_test.sv
module spbcr_test
    import spbcr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // ---------------------------------------------------------------
    // signals
    // ---------------------------------------------------------------
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [9:0] avs_address;
    logic avs_read, avs_write, avs_waitrequest, stuck;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [3:0] avs_byteenable, intx_assert;
    logic strap_upstream = 1'b1;
    logic strap_mode_1p1 = 1'b1;
    logic sec_poison_seen = 1'b0;
    logic sec_err_msg = 1'b0;
    logic cmd_err_report_en = 1'b0;
    logic devctl_err_report_en = 1'b0;
    logic intx_request = 1'b0;
    logic io_valid = 1'b0;
    logic [31:0] io_addr = '0;
    logic [31:0] io_base = '0;
    logic [31:0] io_limit = '0;
    logic poison_report, err_forward, io_route_down, io_route_up;
    logic upstream_sbr, downstream_sbr;
    int err_count = 0;
    int n_compared = 0;
    // one row: address, write data, lanes, expected read back
    typedef struct packed
    {
        logic [9:0] a;
        logic [31:0] d;
        logic [3:0] be;
        logic [31:0] e;
    } spbcr_row_s;
    spbcr_row_s rows [0:10];

    // 20 MHz clock
    always #25 core_clk = !core_clk;

    // ---------------------------------------------------------------
    // instances
    // ---------------------------------------------------------------
    spbcr_host spbcr_host_i (.core_clk(core_clk),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .stuck(stuck));
    spbcr_regs spbcr_regs_i (.core_clk(core_clk), .rst_n(rst_n),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .strap_upstream(strap_upstream), .strap_mode_1p1(strap_mode_1p1),
        .sec_poison_seen(sec_poison_seen), .sec_err_msg(sec_err_msg),
        .cmd_err_report_en(cmd_err_report_en),
        .devctl_err_report_en(devctl_err_report_en),
        .poison_report(poison_report), .err_forward(err_forward),
        .io_valid(io_valid), .io_addr(io_addr), .io_base(io_base),
        .io_limit(io_limit), .io_route_down(io_route_down),
        .io_route_up(io_route_up), .intx_request(intx_request),
        .intx_assert(intx_assert), .upstream_sbr(upstream_sbr),
        .downstream_sbr(downstream_sbr));

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic wr(logic [9:0] a, logic [31:0] d);
        spbcr_host_i.xfer(1'b1, a, d, 4'hF, q);
    endtask

    task automatic rd(string nm, logic [9:0] a, logic [31:0] e);
        spbcr_host_i.xfer(1'b0, a, 32'h0, 4'hF, q);
        chk(nm, q, e);
    endtask

    // events for one cycle: poison, error, cmd en, devctl en, intx
    task automatic step(logic [4:0] v);
        @(posedge core_clk);
        {sec_poison_seen, sec_err_msg, cmd_err_report_en,
            devctl_err_report_en, intx_request} <= v;
        @(posedge core_clk);
        {sec_poison_seen, sec_err_msg, cmd_err_report_en,
            devctl_err_report_en, intx_request} <= 5'h00;
        @(negedge core_clk);
    endtask

    // one routing query; expected {down, up} a cycle later
    task automatic route(logic [31:0] a, logic [31:0] b,
        logic [31:0] l, logic [1:0] e);
        @(posedge core_clk);
        io_valid <= 1'b1;
        io_addr <= a;
        io_base <= b;
        io_limit <= l;
        @(posedge core_clk);
        io_valid <= 1'b0;
        @(negedge core_clk);
        chk("route", {30'h0, io_route_down, io_route_up}, {30'h0, e});
    endtask

    task automatic sbr(logic [1:0] e);
        repeat (2) @(negedge core_clk);
        chk("sbr", {30'h0, upstream_sbr, downstream_sbr}, {30'h0, e});
    endtask

    // a hung access ends the run
    always @(posedge stuck)
    begin
        err_count++;
        test_done();
    end

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial
    begin
        // pin codes stay 0..4, slot stays 0 on the upstream port
        rows = '{'{10'h0F4, 32'hFFFFFF02, 4'hF, 32'h02},
            '{10'h0F8, 32'hFFFFFFFF, 4'hF, 32'h5F},
            '{10'h0F8, 32'h0, 4'hF, 32'h0},
            '{10'h100, 32'hFFFFFFFF, 4'hF, 32'h0051C010},
            '{10'h140, 32'h1, 4'hF, 32'h1},
            '{10'h100, 32'h0, 4'hF, 32'h00500010},
            '{10'h100, 32'hFEFFFFFF, 4'hF, 32'h405FFF10},
            '{10'h100, 32'h0000C000, 4'h2, 32'h405FC010},
            '{10'h140, 32'h0, 4'hF, 32'h0},
            '{10'h100, 32'h0, 4'hF, 32'h405FC010},
            '{10'h3FC, 32'hFFFFFFFF, 4'hF, 32'h0}};
        repeat (10) @(posedge core_clk);
        chk("wait_in_reset", {31'h0, avs_waitrequest}, 32'h1);
        rst_n <= 1'b1;
        rd("pin_rst", 10'h0F4, 32'h0);
        rd("ctl_rst", 10'h0F8, 32'h0);
        rd("cap_rst", 10'h100, 32'h0051C010);
        foreach (rows[i])
        begin
            spbcr_host_i.xfer(1'b1, rows[i].a, rows[i].d, rows[i].be, q);
            rd("row", rows[i].a, rows[i].e);
        end
        // poison and error forwarding
        wr(10'h0F8, 32'h03);
        step(5'b10000);
        chk("poison", {31'h0, poison_report}, 32'h1);
        step(5'b01100);
        chk("errfwd_cmd", {31'h0, err_forward}, 32'h1);
        step(5'b01010);
        chk("errfwd_dev", {31'h0, err_forward}, 32'h1);
        step(5'b01000);
        chk("errfwd_off", {31'h0, err_forward}, 32'h0);
        wr(10'h0F8, 32'h00);
        step(5'b11110);
        chk("ev_off", {30'h0, poison_report, err_forward}, 32'h0);
        // pin codes 0 to 4, each with a one-cycle request
        for (int c = 0; c < 5; c++)
        begin
            wr(10'h0F4, c);
            step(5'b00001);
            chk("intx", intx_assert, c == 0 ? 0 : 1 << (c - 1));
        end
        // routing: window, isa, vga narrow and wide
        route(32'h1100, 32'h1000, 32'h1FFF, 2'b10);
        route(32'h3000, 32'h1000, 32'h1FFF, 2'b01);
        route(32'h03C0, 32'h8000, 32'h8FFF, 2'b01);
        wr(10'h0F8, 32'h04);
        route(32'h1100, 32'h1000, 32'h1FFF, 2'b01);
        route(32'h1000, 32'h1000, 32'h1FFF, 2'b10);
        route(32'h10100, 32'h10000, 32'h1FFFF, 2'b10);
        wr(10'h0F8, 32'h10);
        route(32'h03C0, 32'h8000, 32'h8FFF, 2'b01);
        wr(10'h0F8, 32'h08);
        route(32'h03C0, 32'h8000, 32'h8FFF, 2'b10);
        route(32'h73C0, 32'h8000, 32'h8FFF, 2'b10);
        wr(10'h0F8, 32'h18);
        route(32'h73C0, 32'h8000, 32'h8FFF, 2'b01);
        route(32'h03B0, 32'h8000, 32'h8FFF, 2'b10);
        wr(10'h0F8, 32'h40);
        sbr(2'b10);
        rd("sts_up", 10'h144, 32'h7);
        // second reset, downstream port outside 1.1 mode
        @(posedge core_clk);
        rst_n <= 1'b0;
        strap_upstream <= 1'b0;
        strap_mode_1p1 <= 1'b0;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        rd("ctl_rst2", 10'h0F8, 32'h0);
        rd("cap_dn", 10'h100, 32'h4062C010);
        wr(10'h0F8, 32'h40);
        sbr(2'b01);
        rd("sts_dn", 10'h144, 32'h8);
        test_done();
    end
endmodule
